// File: net_guard_params.svh
// constants for the command source guard: offsets, fields, reset values, timing
// Operation
// RULE1: four base address octets, each 0 to 255, zero after reset.
// RULE2: all four base octets zero means no peer may command the drive.
// RULE3: third and fourth octets accepted between base and range, either bound larger.
// RULE4: range value 9999 disables the range; octet must equal base exactly.
// RULE5: traffic stops from all allowed peers: raise loss fault, shut output off.
// RULE6: check interval 9999 turns signal loss detection off.
// RULE7: interval 0 serves reads but faults at once entering network mode.
// RULE8: interval 0 with network start-up mode: one exchange, then fault.
// RULE9: peers must send at intervals no longer than the check interval.
// RULE10: any received data from allowed peers clears the loss counter; the code clears it only on admitted operation frames.
// RULE11: loss check starts at first frame in network mode with Ethernet source.
// RULE12: address and range settings take effect only after a drive reset.
// RULE13: app enabled when a slot holds 44818, unless any slot holds 45238.
// RULE14: peers should use interval 9999 or above their cycle and retry time.
// RULE15: operation commands honoured only from frames whose source address matches.
`ifndef NET_GUARD_PARAMS_SVH
`define NET_GUARD_PARAMS_SVH

// register byte offsets
`define OFS_BASE_ADDR     8'h00
`define OFS_RANGE3        8'h04
`define OFS_RANGE4        8'h08
`define OFS_INTERVAL      8'h0C
`define OFS_FUNC12        8'h10
`define OFS_FUNC34        8'h14
`define OFS_EVENT_STATUS  8'h18
`define OFS_EVENT_MASK    8'h1C
`define OFS_GUARD_STATE   8'h20

// event status bit positions
`define EVT_FAULT         0
`define EVT_REJECT        1
`define EVT_ACCEPT        2

// reset values and special codes
`define BASE_RESET        32'h0000_0000
`define RANGE_OFF         14'h270F
`define INTERVAL_OFF      14'h270F
`define INTERVAL_RESET    14'h0000
`define SLOT1_RESET       16'h1389
`define SLOT2_RESET       16'hB0B5
`define SLOT3_RESET       16'hB0B6
`define SLOT4_RESET       16'h270F
`define APP_ENIP          16'hAF12
`define APP_BLOCKER       16'hB0B6

// timing: one interval unit is 0.1 s
`define CLK_PERIOD_NS     50
`define LOSS_UNIT_NS      100000000

`endif

// File: net_guard_pkg.sv
// types shared by the command source guard
package net_guard_pkg;
  typedef enum logic [1:0] {
    LOSS_IDLE,
    LOSS_ARMED,
    LOSS_FAULTED
  } loss_state_type;
  typedef logic [13:0] setting_type;
  typedef logic [15:0] slot_type;
endpackage

// File: src_match.sv
// source address matcher for incoming frames
`timescale 1ns/1ns
`include "net_guard_params.svh"
module src_match
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // frame in
  input  wire logic                      in_valid,
  input  wire logic [31:0]               src_ip,
  // active settings
  input  wire logic [31:0]               base_ip,
  input  wire net_guard_pkg::setting_type range3,
  input  wire net_guard_pkg::setting_type range4,
  // result
  output logic                           match_valid,
  output logic                           match
);
  import net_guard_pkg::*;

  logic next_match_valid;
  logic next_match;

  // octet inside the ordered pair of bounds, or exact when range is off
  function automatic logic octet_ok(input logic [7:0] src, input logic [7:0] base, input setting_type rng);
    setting_type s;
    setting_type b;
    s = {6'h00, src};
    b = {6'h00, base};
    if (rng == `RANGE_OFF)
      octet_ok = (src == base); // see RULE4
    else if (b <= rng)
      octet_ok = (s >= b) && (s <= rng); // see RULE3
    else
      octet_ok = (s >= rng) && (s <= b); // see RULE3
  endfunction

  // all zero base admits nobody
  always_comb
  begin
    next_match_valid = in_valid;
    next_match = (base_ip != `BASE_RESET) // see RULE2
      && (src_ip[31:24] == base_ip[31:24])
      && (src_ip[23:16] == base_ip[23:16])
      && octet_ok(src_ip[15:8], base_ip[15:8], range3)
      && octet_ok(src_ip[7:0], base_ip[7:0], range4);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      match_valid <= 1'b0;
      match       <= 1'b0;
    end
    else
    begin
      match_valid <= next_match_valid;
      match       <= next_match;
    end
  end
endmodule

// File: loss_timer.sv
// signal loss timer counting whole interval units
`timescale 1ns/1ns
`include "net_guard_params.svh"
module loss_timer
#(
  parameter int UNIT_CYCLES = `LOSS_UNIT_NS / `CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // control
  input  wire logic                      run,
  input  wire logic                      restart,
  input  wire net_guard_pkg::setting_type interval,
  // result
  output logic                           expired
);
  import net_guard_pkg::*;

  logic [31:0] prescale;
  setting_type units;
  logic [31:0] next_prescale;
  setting_type next_units;
  logic        next_expired;

  // counts units of 0.1 s; any restart pulse puts the count back to zero
  always_comb
  begin
    next_prescale = prescale;
    next_units    = units;
    next_expired  = 1'b0;
    if (!run || restart)
    begin
      next_prescale = 32'h0000_0000; // see RULE10
      next_units    = 14'h0000;
    end
    else if (prescale == 32'(UNIT_CYCLES - 1))
    begin
      next_prescale = 32'h0000_0000;
      if (units != 14'h3FFF)
        next_units = units + 14'h0001;
    end
    else
      next_prescale = prescale + 32'h0000_0001;
    // expiry only for a real interval; zero and off are handled outside
    if (run && !restart && interval != 14'h0000 && interval != `INTERVAL_OFF && units >= interval)
      next_expired = 1'b1; // see RULE5
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prescale <= 32'h0000_0000;
      units    <= 14'h0000;
      expired  <= 1'b0;
    end
    else
    begin
      prescale <= next_prescale;
      units    <= next_units;
      expired  <= next_expired;
    end
  end
endmodule

// File: net_command_source_guard.sv
// command source guard: APB settings, source admission and signal loss fault
`timescale 1ns/1ns
`include "net_guard_params.svh"
module net_command_source_guard
#(
  parameter int UNIT_CYCLES = `LOSS_UNIT_NS / `CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // drive context
  input  wire logic        drive_reset,
  input  wire logic        network_operation_mode,
  input  wire logic        ethernet_cmd_source,
  // received frames
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_src_ip,
  input  wire logic        rx_is_operation,
  // results
  output logic             cmd_accept,
  output logic             cmd_reject,
  output logic             comm_loss_fault,
  output logic             output_shutoff,
  output logic             net_app_enable,
  output logic             irq
);
  import net_guard_pkg::*;

  // written settings, pending until a drive reset
  logic [31:0]    pend_base;
  setting_type    pend_range3;
  setting_type    pend_range4;
  setting_type    pend_interval;
  slot_type       pend_slot [4];
  // settings in force
  logic [31:0]    act_base;
  setting_type    act_range3;
  setting_type    act_range4;
  setting_type    loss_check_interval;
  logic [2:0]     event_status;
  logic [2:0]     event_mask;
  logic [31:0]    next_pend_base;
  setting_type    next_pend_range3;
  setting_type    next_pend_range4;
  setting_type    next_pend_interval;
  slot_type       next_pend_slot [4];
  logic [31:0]    next_act_base;
  setting_type    next_act_range3;
  setting_type    next_act_range4;
  setting_type    next_interval;
  logic [2:0]     next_event_status;
  logic [2:0]     next_event_mask;
  logic           next_pready;
  logic [31:0]    next_prdata;
  logic           next_pslverr;
  logic           next_app;
  logic           next_irq;
  // guard state
  loss_state_type state;
  loss_state_type next_state;
  logic           startup_net;
  logic           first_cycle;
  logic           exchanged;
  logic           next_startup_net;
  logic           next_first_cycle;
  logic           next_exchanged;
  logic           next_accept;
  logic           next_reject;
  logic           next_fault;
  logic           match_valid;
  logic           match;
  logic           expired;
  logic           net_active;
  logic           wr_en;
  logic           raise_fault;
  logic           app_hit;
  logic           app_block;

  assign wr_en = psel && penable && pready && pwrite;
  assign net_active = network_operation_mode && ethernet_cmd_source;

  // admission is judged one cycle after the frame arrives
  src_match u_match
  (
    .mclk        (mclk),
    .reset       (reset),
    .in_valid    (rx_valid && rx_is_operation && net_app_enable),
    .src_ip      (rx_src_ip),
    .base_ip     (act_base),
    .range3      (act_range3),
    .range4      (act_range4),
    .match_valid (match_valid),
    .match       (match)
  );

  loss_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_timer
  (
    .mclk     (mclk),
    .reset    (reset),
    .run      (state == LOSS_ARMED && loss_check_interval != `INTERVAL_OFF), // see RULE6
    .restart  (match_valid && match), // see RULE10
    .interval (loss_check_interval),
    .expired  (expired)
  );

  // application select across the four slots, only the loaded values count
  always_comb
  begin
    app_hit   = 1'b0;
    app_block = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      app_hit   = app_hit   || (pend_slot[i] == `APP_ENIP);
      app_block = app_block || (pend_slot[i] == `APP_BLOCKER);
    end
  end

  // register file and apb answers; pready rises in the second access cycle
  always_comb
  begin
    next_pend_base     = pend_base;
    next_pend_range3   = pend_range3;
    next_pend_range4   = pend_range4;
    next_pend_interval = pend_interval;
    next_pend_slot     = pend_slot;
    next_act_base      = act_base;
    next_act_range3    = act_range3;
    next_act_range4    = act_range4;
    next_interval      = loss_check_interval;
    next_event_mask    = event_mask;
    next_event_status  = event_status;
    next_app           = net_app_enable;
    next_pready        = psel && penable && !pready;
    next_prdata        = 32'h0000_0000;
    next_pslverr       = 1'b0;
    case (paddr)
      `OFS_BASE_ADDR:    next_prdata = pend_base;
      `OFS_RANGE3:       next_prdata = {18'h00000, pend_range3};
      `OFS_RANGE4:       next_prdata = {18'h00000, pend_range4};
      `OFS_INTERVAL:     next_prdata = {18'h00000, pend_interval};
      `OFS_FUNC12:       next_prdata = {pend_slot[1], pend_slot[0]};
      `OFS_FUNC34:       next_prdata = {pend_slot[3], pend_slot[2]};
      `OFS_EVENT_STATUS: next_prdata = {29'h0000_0000, event_status};
      `OFS_EVENT_MASK:   next_prdata = {29'h0000_0000, event_mask};
      `OFS_GUARD_STATE:  next_prdata = {26'h000_0000, startup_net, exchanged, net_app_enable,
                                        state == LOSS_ARMED, comm_loss_fault, act_base != `BASE_RESET};
      default:           next_pslverr = psel && penable && !pready;
    endcase
    if (wr_en)
    begin
      case (paddr)
        `OFS_BASE_ADDR:    next_pend_base = pwdata; // see RULE1
        `OFS_RANGE3:       next_pend_range3 = pwdata[13:0];
        `OFS_RANGE4:       next_pend_range4 = pwdata[13:0];
        `OFS_INTERVAL:     next_pend_interval = pwdata[13:0];
        `OFS_FUNC12:
        begin
          next_pend_slot[0] = pwdata[15:0];
          next_pend_slot[1] = pwdata[31:16];
        end
        `OFS_FUNC34:
        begin
          next_pend_slot[2] = pwdata[15:0];
          next_pend_slot[3] = pwdata[31:16];
        end
        `OFS_EVENT_STATUS: next_event_status = event_status & ~pwdata[2:0];
        `OFS_EVENT_MASK:   next_event_mask = pwdata[2:0];
        default:           next_event_mask = event_mask;
      endcase
    end
    // hardware events win over a clear in the same cycle
    next_event_status[`EVT_FAULT]  = next_event_status[`EVT_FAULT]  || raise_fault;
    next_event_status[`EVT_REJECT] = next_event_status[`EVT_REJECT] || next_reject;
    next_event_status[`EVT_ACCEPT] = next_event_status[`EVT_ACCEPT] || next_accept;
    // settings move into force only on a drive reset
    if (drive_reset)
    begin
      next_act_base   = pend_base; // see RULE12
      next_act_range3 = pend_range3;
      next_act_range4 = pend_range4;
      next_interval   = pend_interval;
      next_app        = app_hit && !app_block; // see RULE13
    end
    next_irq = |(next_event_status & event_mask);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pend_base           <= `BASE_RESET;
      pend_range3         <= `RANGE_OFF;
      pend_range4         <= `RANGE_OFF;
      pend_interval       <= `INTERVAL_RESET;
      pend_slot[0]        <= `SLOT1_RESET;
      pend_slot[1]        <= `SLOT2_RESET;
      pend_slot[2]        <= `SLOT3_RESET;
      pend_slot[3]        <= `SLOT4_RESET;
      act_base            <= `BASE_RESET;
      act_range3          <= `RANGE_OFF;
      act_range4          <= `RANGE_OFF;
      loss_check_interval <= `INTERVAL_RESET;
      event_status        <= 3'h0;
      event_mask          <= 3'h0;
      net_app_enable      <= 1'b0;
      pready              <= 1'b0;
      prdata              <= 32'h0000_0000;
      pslverr             <= 1'b0;
      irq                 <= 1'b0;
    end
    else
    begin
      pend_base           <= next_pend_base;
      pend_range3         <= next_pend_range3;
      pend_range4         <= next_pend_range4;
      pend_interval       <= next_pend_interval;
      pend_slot           <= next_pend_slot;
      act_base            <= next_act_base;
      act_range3          <= next_act_range3;
      act_range4          <= next_act_range4;
      loss_check_interval <= next_interval;
      event_status        <= next_event_status;
      event_mask          <= next_event_mask;
      net_app_enable      <= next_app;
      pready              <= next_pready;
      prdata              <= next_prdata;
      pslverr             <= next_pslverr;
      irq                 <= next_irq;
    end
  end

  // loss supervision; interval zero faults at once unless started in network mode
  always_comb
  begin
    next_state       = state;
    next_first_cycle = 1'b0;
    next_startup_net = startup_net;
    next_exchanged   = exchanged;
    next_accept      = match_valid && match && state != LOSS_FAULTED; // see RULE15
    next_reject      = match_valid && !(match && state != LOSS_FAULTED); // see RULE2
    raise_fault      = 1'b0;
    // start-up mode is caught on the first clocked cycle after reset
    if (first_cycle)
      next_startup_net = net_active;
    if (match_valid && match && net_active)
      next_exchanged = 1'b1;
    case (state)
      LOSS_IDLE:
      begin
        if (net_active && loss_check_interval == 14'h0000 && !first_cycle
            && (!startup_net || next_exchanged))
          raise_fault = 1'b1; // see RULE7 and RULE8
        else if (net_active && match_valid && match)
          next_state = LOSS_ARMED; // see RULE11
      end
      LOSS_ARMED:
      begin
        if (!net_active)
          next_state = LOSS_IDLE;
        else if (expired || loss_check_interval == 14'h0000)
          raise_fault = 1'b1; // see RULE5
      end
      LOSS_FAULTED:  next_state = LOSS_FAULTED;
      default:       next_state = LOSS_IDLE;
    endcase
    if (raise_fault)
      next_state = LOSS_FAULTED;
    // a drive reset clears the fault and starts supervision afresh
    if (drive_reset)
    begin
      next_state     = LOSS_IDLE;
      next_exchanged = 1'b0;
    end
    next_fault = (next_state == LOSS_FAULTED);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state           <= LOSS_IDLE;
      first_cycle     <= 1'b1;
      startup_net     <= 1'b0;
      exchanged       <= 1'b0;
      cmd_accept      <= 1'b0;
      cmd_reject      <= 1'b0;
      comm_loss_fault <= 1'b0;
      output_shutoff  <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      first_cycle     <= next_first_cycle;
      startup_net     <= next_startup_net;
      exchanged       <= next_exchanged;
      cmd_accept      <= next_accept;
      cmd_reject      <= next_reject;
      comm_loss_fault <= next_fault;
      output_shutoff  <= next_fault; // see RULE5
    end
  end
endmodule

// File: ncsg_properties.sv
// port checker for the command source guard, bound to its top module
`timescale 1ns/1ns
module ncsg_properties
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // drive context
  input wire logic        drive_reset,
  input wire logic        network_operation_mode,
  input wire logic        ethernet_cmd_source,
  // received frames
  input wire logic        rx_valid,
  input wire logic [31:0] rx_src_ip,
  input wire logic        rx_is_operation,
  // results
  input wire logic        cmd_accept,
  input wire logic        cmd_reject,
  input wire logic        comm_loss_fault,
  input wire logic        output_shutoff,
  input wire logic        net_app_enable,
  input wire logic        irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // frame judging: one verdict, two cycles on, never unprompted
  a_frame_answer: assert property (
    (rx_valid && rx_is_operation && net_app_enable) |-> ##2 (cmd_accept != cmd_reject))
    else $error("judged frame without a single verdict");
  a_no_stray: assert property (
    (cmd_accept || cmd_reject) |-> $past(rx_valid && rx_is_operation && net_app_enable, 2))
    else $error("verdict without a judged frame");
  // fault behaviour: no admission while faulted, sticky until drive reset
  a_accept_unfaulted: assert property (
    cmd_accept |-> !$past(comm_loss_fault))
    else $error("frame admitted while faulted");
  a_shutoff_equal: assert property (output_shutoff == comm_loss_fault)
    else $error("shutoff differs from fault");
  a_fault_sticky: assert property (
    (comm_loss_fault && !drive_reset) |=> comm_loss_fault)
    else $error("fault dropped without drive reset");
  a_fault_clear: assert property (drive_reset |=> !comm_loss_fault)
    else $error("fault survived drive reset");
  a_fault_cause: assert property (
    $rose(comm_loss_fault) |-> $past(network_operation_mode && ethernet_cmd_source))
    else $error("fault outside network operation");
  // settings only move on a drive reset
  a_app_on_reset: assert property ($changed(net_app_enable) |-> $past(drive_reset))
    else $error("app enable changed without drive reset");
  // apb answer shape
  a_ready_second: assert property ((psel && penable && !pready && !$past(penable)) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule

bind net_command_source_guard ncsg_properties chk (.*);

// File: eth_master_model.sv
// network master model sending frames into the guard
`timescale 1ns/1ns
module eth_master_model
(
  // clock
  input wire logic    mclk,
  // frame out
  output logic        rx_valid,
  output logic [31:0] rx_src_ip,
  output logic        rx_is_operation
);
  initial
  begin
    rx_valid = 1'b0;
    rx_src_ip = 32'h0000_0000;
    rx_is_operation = 1'b0;
  end

  // one frame after gap idle cycles; a slow master passes a large gap
  task send(input logic [31:0] ip, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_src_ip <= ip;
    rx_is_operation <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_is_operation <= 1'b0;
    rx_src_ip <= ~ip; // stale address must never pass for a frame
  endtask

  // keep-alive traffic spaced well inside the check interval
  task beat(input logic [31:0] ip, input int count, input int gap);
    repeat (count) send(ip, gap);
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the command source guard
`timescale 1ns/1ns
`include "net_guard_params.svh"
module testbench;
  import net_guard_pkg::*;
  typedef struct {
    logic [31:0] base;
    setting_type r3;
    setting_type r4;
    logic [31:0] ip;
    logic        ok;
  } row_type;
  localparam setting_type OFF = `RANGE_OFF;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, ip_a;
  logic        drive_reset, network_operation_mode, ethernet_cmd_source;
  logic        rx_valid, rx_is_operation, cmd_accept, cmd_reject;
  logic [31:0] rx_src_ip;
  logic        comm_loss_fault, output_shutoff, net_app_enable, irq;
  int          mismatches, check_count, n_acc, n_rej;
  logic [7:0]  ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  logic [31:0] rv[10] = '{`BASE_RESET, {18'h0, OFF}, {18'h0, OFF}, {18'h0, `INTERVAL_RESET},
                          {`SLOT2_RESET, `SLOT1_RESET}, {`SLOT4_RESET, `SLOT3_RESET}, 32'h0, 32'h0, 32'h20, 32'h0};
  row_type     rows[13] = '{
    '{32'h0000_0000, OFF, OFF, 32'h0000_0000, 1'b0},
    '{32'hC0A8_0164, 14'h0003, 14'h0096, 32'hC0A8_0164, 1'b1},
    '{32'hC0A8_0164, 14'h0003, 14'h0096, 32'hC0A8_0396, 1'b1},
    '{32'hC0A8_0164, 14'h0003, 14'h0096, 32'hC0A8_0464, 1'b0},
    '{32'hC0A8_0164, 14'h0003, 14'h0096, 32'hC0A8_0063, 1'b0},
    '{32'hC0A8_0164, 14'h0003, 14'h0096, 32'hC0A8_0197, 1'b0},
    '{32'hC0A8_0164, 14'h0003, 14'h0096, 32'hC0A9_0164, 1'b0},
    '{32'hC0A8_0264, OFF, 14'h0032, 32'hC0A8_0232, 1'b1},
    '{32'hC0A8_0264, OFF, 14'h0032, 32'hC0A8_0231, 1'b0},
    '{32'hC0A8_0264, OFF, 14'h0032, 32'hC0A8_0364, 1'b0},
    '{32'hC0A8_0564, 14'h0002, OFF, 32'hC0A8_0364, 1'b1},
    '{32'hC0A8_0564, 14'h0002, OFF, 32'hC0A8_0164, 1'b0},
    '{32'hC0A8_0564, 14'h0002, OFF, 32'hC0A8_0565, 1'b0}};

  // device under test with a short interval unit
  net_command_source_guard #(.UNIT_CYCLES(10)) uut (.*);
  eth_master_model mst (.*);

  // clock and verdict counters
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (cmd_accept === 1'b1) n_acc++;
    if (cmd_reject === 1'b1) n_rej++;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // apb master: waits for pready with no assumed latency
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk("pready", 1, pready);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task dreset;
    @(posedge mclk);
    drive_reset <= 1'b1;
    @(posedge mclk);
    drive_reset <= 1'b0;
    @(posedge mclk);
  endtask

  // one frame, then count the verdicts it produced
  task frame(input logic [31:0] ip, input logic acc, input logic rej);
    int a0;
    int r0;
    a0 = n_acc;
    r0 = n_rej;
    mst.send(ip, 0);
    repeat (4) @(posedge mclk);
    chk("accepts", {31'h0, acc}, n_acc - a0);
    chk("rejects", {31'h0, rej}, n_rej - r0);
  endtask

  task wait_fault(input int lim);
    int n;
    n = 0;
    while (comm_loss_fault !== 1'b1 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #1000000;
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    end_sim;
  end

  // main sequence
  initial
  begin
    {psel, penable, pwrite, drive_reset, network_operation_mode, ethernet_cmd_source} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset = 1'b1;
    {mismatches, check_count, n_acc, n_rej} = {32'h0, 32'h0, 32'h0, 32'h0};
    ip_a = 32'hC0A8_0164;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b1, `OFS_FUNC12, {`SLOT2_RESET, `APP_ENIP}, q, e);
    dreset;
    chk("app blocked", 0, net_app_enable);
    frame(ip_a, 1'b0, 1'b0);
    apb(1'b1, `OFS_FUNC34, {`SLOT4_RESET, `APP_ENIP}, q, e);
    apb(1'b1, `OFS_INTERVAL, {18'h0, `INTERVAL_OFF}, q, e);
    dreset;
    chk("app enabled", 1, net_app_enable);
    foreach (rows[i])
    begin
      apb(1'b1, `OFS_BASE_ADDR, rows[i].base, q, e);
      apb(1'b1, `OFS_RANGE3, {18'h0, rows[i].r3}, q, e);
      apb(1'b1, `OFS_RANGE4, {18'h0, rows[i].r4}, q, e);
      dreset;
      frame(rows[i].ip, rows[i].ok, !rows[i].ok);
    end
    // loss detection with a three unit interval, fault masked in only
    apb(1'b1, `OFS_BASE_ADDR, ip_a, q, e);
    apb(1'b1, `OFS_RANGE3, {18'h0, OFF}, q, e);
    apb(1'b1, `OFS_RANGE4, {18'h0, OFF}, q, e);
    apb(1'b1, `OFS_INTERVAL, 32'h0000_0003, q, e);
    apb(1'b1, `OFS_EVENT_MASK, 32'h0000_0001, q, e);
    network_operation_mode <= 1'b1;
    ethernet_cmd_source <= 1'b1;
    dreset;
    repeat (60) @(posedge mclk);
    chk("unarmed fault", 0, comm_loss_fault);
    mst.beat(ip_a, 6, 6);
    chk("fed fault", 0, comm_loss_fault);
    chk("masked irq", 0, irq);
    repeat (12) @(posedge mclk);
    chk("early fault", 0, comm_loss_fault);
    wait_fault(40);
    chk("loss fault", 1, comm_loss_fault);
    chk("shutoff", 1, output_shutoff);
    chk("fault irq", 1, irq);
    apb(1'b0, `OFS_EVENT_STATUS, 32'h0, q, e);
    chk("status fault", 1, q[`EVT_FAULT]);
    frame(ip_a, 1'b0, 1'b1);
    dreset;
    chk("fault cleared", 0, comm_loss_fault);
    apb(1'b1, `OFS_EVENT_STATUS, 32'h0000_0001, q, e);
    @(posedge mclk);
    chk("irq cleared", 0, irq);
    // interval off: armed but never faults
    apb(1'b1, `OFS_INTERVAL, {18'h0, `INTERVAL_OFF}, q, e);
    dreset;
    frame(ip_a, 1'b1, 1'b0);
    repeat (80) @(posedge mclk);
    chk("off fault", 0, comm_loss_fault);
    // interval zero: reads served, fault on entering network mode
    network_operation_mode <= 1'b0;
    apb(1'b1, `OFS_INTERVAL, 32'h0, q, e);
    dreset;
    apb(1'b0, `OFS_INTERVAL, 32'h0, q, e);
    chk("zero read", 0, {q[31:1], e});
    chk("zero idle", 0, comm_loss_fault);
    network_operation_mode <= 1'b1;
    wait_fault(10);
    chk("zero fault", 1, comm_loss_fault);
    network_operation_mode <= 1'b0;
    dreset;
    // pending address held back until drive reset
    apb(1'b1, `OFS_INTERVAL, {18'h0, `INTERVAL_OFF}, q, e);
    apb(1'b1, `OFS_BASE_ADDR, 32'hC0A8_0A01, q, e);
    frame(32'hC0A8_0A01, 1'b0, 1'b1);
    frame(ip_a, 1'b1, 1'b0);
    dreset;
    frame(32'hC0A8_0A01, 1'b1, 1'b0);
    // second reset mid-run, network start-up mode: defaults and unmapped address
    network_operation_mode <= 1'b1;
    reset <= 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    chk("reset app", 0, net_app_enable);
    chk("reset fault", 0, comm_loss_fault);
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0, q, e);
      chk("reset value", rv[i], q);
      chk("slave error", {31'h0, ra[i] == 8'h24}, {31'h0, e});
    end
    chk("startup idle", 0, comm_loss_fault);
    apb(1'b1, `OFS_FUNC34, {`SLOT4_RESET, `APP_ENIP}, q, e);
    apb(1'b1, `OFS_BASE_ADDR, ip_a, q, e);
    dreset;
    frame(ip_a, 1'b1, 1'b0);
    chk("startup fault", 1, comm_loss_fault);
    end_sim;
  end
endmodule
